// ### atd_pkg.sv
package atd_pkg;
  localparam int unsigned clk_mhz = 250;
  // timing figures as printed
  localparam int unsigned alarm_limit_ms = 2000;
  localparam int unsigned normal_limit_ms = 2000;
  // cycle counts derived from the clock rate (exact products, no rounding)
  localparam int unsigned alarm_limit_cyc = alarm_limit_ms * 1000 * clk_mhz;
  localparam int unsigned normal_limit_cyc = normal_limit_ms * 1000 * clk_mhz;
  localparam int unsigned num_circuits = 4;
  localparam int unsigned cnt_w = 32;
  localparam int unsigned circ_w = 2;
  // apb register map
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_status = 8'h04;
  localparam logic [7:0] addr_istat = 8'h08;
  localparam logic [7:0] addr_iclr = 8'h0c;
  localparam logic [7:0] addr_ien = 8'h10;
  // ctrl register fields
  localparam int unsigned ctrl_enable_bit = 0;
  localparam logic [31:0] ctrl_reset_val = 32'h0000_0001;
  // interrupt status fields
  localparam int unsigned irq_pass_bit = 0;
  localparam int unsigned irq_fail_bit = 1;
  localparam int unsigned irq_w = 2;
  typedef enum logic [2:0] {
    atd_idle = 3'b000,
    atd_drive = 3'b001,
    atd_release = 3'b010,
    atd_next = 3'b011,
    atd_finish = 3'b100
  } atd_state_e;
endpackage

// ### atd_sequencer.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - try the detector test when a charger inhibit hour begins
// - after pass or fail, no new test until the next inhibit hour
// - hold off on panel reset, fire, self-test, non-latching, zone indicators
// - start at once when hold-off clears inside the inhibit hour
// - circuit must reach alarm within 2 s of test signal, else failed
// - after signal withdrawn circuit must return normal within 2 s
// - visit each of the 4 circuits exactly once per run, in order
// - failed circuit lights its zone defect steady; controller enters defect
// - test-raised defect persists until a test runs in a later inhibit hour
// - all pass clears controller defect, zone defects left alone
// - zone defect indicators clear only on panel reset
// - test alarms never latched nor forwarded to brigade or evacuation
// - real fire on tested circuit may report up to about 2 s late (the return-to-normal limit), with fail
// - fire on circuits not under test reported without delay
// - inhibit hour recurs every 24 h for 1 h and frames the test window
module atd_sequencer #(
  parameter int unsigned alarm_limit = atd_pkg::alarm_limit_cyc,
  parameter int unsigned normal_limit = atd_pkg::normal_limit_cyc
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic charger_inhibit,
  input wire logic panel_reset,
  input wire logic fire_state,
  input wire logic self_test_active,
  input wire logic self_test_failed,
  input wire logic non_latching,
  input wire logic zone_alarm_any,
  input wire logic [3:0] circuit_alarm,
  output logic [3:0] test_signal,
  output logic [3:0] zone_defect,
  output logic [3:0] alarm_forward,
  output logic test_defect,
  output logic test_running,
  output logic irq
);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  atd_pkg::atd_state_e state, next_state;
  logic [atd_pkg::cnt_w-1:0] timer, next_timer;
  logic [atd_pkg::circ_w-1:0] circ, next_circ;
  logic [3:0] run_fail, next_run_fail;
  logic [3:0] next_test_signal, next_zone_defect, next_alarm_forward;
  logic next_test_defect, done, next_done, inhibit_d, next_test_running;
  logic [31:0] ctrl, next_ctrl;
  logic [atd_pkg::irq_w-1:0] istat, next_istat, ien, next_ien;
  logic ev_pass, ev_fail, hold_off, hour_start, enable;

  // software enable, set after reset
  assign enable = ctrl[atd_pkg::ctrl_enable_bit];
  assign hour_start = charger_inhibit & ~inhibit_d;
  // any condition that keeps the test from starting
  assign hold_off = panel_reset | fire_state | self_test_active | self_test_failed |
                    non_latching | (|zone_defect) | zone_alarm_any;

  // next state of the test sequence
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_circ = circ;
    next_run_fail = run_fail;
    next_test_signal = 4'h0;
    next_done = done;
    next_test_defect = test_defect;
    next_zone_defect = zone_defect;
    ev_pass = 1'b0;
    ev_fail = 1'b0;
    if (hour_start) begin
      next_done = 1'b0;
    end
    unique case (state)
      atd_pkg::atd_idle: begin
        // window framed by the inhibit input
        if (charger_inhibit && !next_done && !hold_off && enable) begin
          next_state = atd_pkg::atd_drive;
          next_circ = '0;
          next_run_fail = 4'h0;
          next_timer = '0;
          next_test_signal[0] = 1'b1;
        end
      end
      atd_pkg::atd_drive: begin
        next_test_signal[circ] = 1'b1;
        if (circuit_alarm[circ]) begin
          next_state = atd_pkg::atd_release;
          next_timer = '0;
          next_test_signal[circ] = 1'b0;
        end else if (timer >= atd_pkg::cnt_w'(alarm_limit - 1)) begin
          next_run_fail[circ] = 1'b1;
          next_state = atd_pkg::atd_next;
          next_test_signal[circ] = 1'b0;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      atd_pkg::atd_release: begin
        if (!circuit_alarm[circ]) begin
          next_state = atd_pkg::atd_next;
        end else if (timer >= atd_pkg::cnt_w'(normal_limit - 1)) begin
          next_run_fail[circ] = 1'b1;
          next_state = atd_pkg::atd_next;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      atd_pkg::atd_next: begin
        next_timer = '0;
        if (circ == atd_pkg::circ_w'(atd_pkg::num_circuits - 1)) begin
          next_state = atd_pkg::atd_finish;
        end else begin
          next_circ = circ + 1'b1;
          next_state = atd_pkg::atd_drive;
          next_test_signal[next_circ] = 1'b1;
        end
      end
      atd_pkg::atd_finish: begin
        next_state = atd_pkg::atd_idle;
        next_done = 1'b1;
        next_zone_defect = zone_defect | run_fail;
        next_test_defect = |run_fail;
        ev_pass = ~(|run_fail);
        ev_fail = |run_fail;
      end
      default: next_state = atd_pkg::atd_idle;
    endcase
    // panel reset is the only clear of the zone defects; a fail on the same edge still lights
    if (panel_reset) begin
      next_zone_defect = (state == atd_pkg::atd_finish) ? run_fail : 4'h0;
    end
  end

  // alarms of the circuit under test are masked, others pass straight on
  always_comb begin
    next_alarm_forward = circuit_alarm;
    next_test_running = (next_state != atd_pkg::atd_idle);
    // the edge that starts a run already masks the first circuit
    if (next_state == atd_pkg::atd_drive || next_state == atd_pkg::atd_release ||
        (state != atd_pkg::atd_idle && state != atd_pkg::atd_finish)) begin
      next_alarm_forward[next_circ] = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= atd_pkg::atd_idle;
      timer <= '0;
      circ <= '0;
      run_fail <= 4'h0;
      test_signal <= 4'h0;
      zone_defect <= 4'h0;
      alarm_forward <= 4'h0;
      test_defect <= 1'b0;
      test_running <= 1'b0;
      done <= 1'b0;
      inhibit_d <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      circ <= next_circ;
      run_fail <= next_run_fail;
      test_signal <= next_test_signal;
      zone_defect <= next_zone_defect;
      alarm_forward <= next_alarm_forward;
      test_defect <= next_test_defect;
      test_running <= next_test_running;
      done <= next_done;
      inhibit_d <= charger_inhibit;
    end
  end

  // ---------------------------------------------------------------
  // apb slave and interrupts
  // ---------------------------------------------------------------
  logic wr_acc;
  logic [31:0] next_prdata;
  logic next_irq, next_pslverr, known;
  // a write lands only at the access edge
  assign wr_acc = psel & penable & pwrite & pready;

  // register writes, sticky status with set winning over clear
  always_comb begin
    next_ctrl = ctrl;
    next_ien = ien;
    next_istat = istat;
    if (wr_acc && paddr == atd_pkg::addr_ctrl) next_ctrl = pwdata;
    if (wr_acc && paddr == atd_pkg::addr_ien) next_ien = pwdata[atd_pkg::irq_w-1:0];
    if (wr_acc && paddr == atd_pkg::addr_iclr) begin
      next_istat = istat & ~pwdata[atd_pkg::irq_w-1:0];
    end
    if (ev_pass) next_istat[atd_pkg::irq_pass_bit] = 1'b1;
    if (ev_fail) next_istat[atd_pkg::irq_fail_bit] = 1'b1;
    next_irq = |(next_istat & next_ien);
  end

  // read mux, answered in the access cycle
  always_comb begin
    next_prdata = 32'h0;
    known = 1'b1;
    unique case (paddr)
      atd_pkg::addr_ctrl: next_prdata = ctrl;
      // status: done, defect, zones, fails, circuit, state
      atd_pkg::addr_status: next_prdata = {17'h0, done, test_defect, zone_defect,
                                           run_fail, circ, state};
      atd_pkg::addr_istat: next_prdata = {30'h0, istat};
      atd_pkg::addr_iclr: next_prdata = 32'h0;
      atd_pkg::addr_ien: next_prdata = {30'h0, ien};
      default: known = 1'b0;
    endcase
    next_pslverr = psel & ~penable & ~known;
  end

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= atd_pkg::ctrl_reset_val;
      ien <= '0;
      istat <= '0;
      irq <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ien <= next_ien;
      istat <= next_istat;
      irq <= next_irq;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
      pready <= psel & ~penable;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // start, repeat and done flag
  a_start_needs_window: assert property ((state == atd_pkg::atd_idle &&
    next_state == atd_pkg::atd_drive) |-> charger_inhibit && !hold_off)
    else $error("test started outside window or while held off");
  a_no_second_run: assert property ($rose(done) |-> !test_running [*2])
    else $error("test restarted in same hour");
  a_done_blocks: assert property ((done && !hour_start &&
    state == atd_pkg::atd_idle) |=> state == atd_pkg::atd_idle)
    else $error("test started with the hour already done");
  a_done_clears_hour: assert property (hour_start |=> !done)
    else $error("done flag not cleared at hour start");
  a_signal_one_hot: assert property ($onehot0(test_signal))
    else $error("more than one circuit driven");
  a_circ_steps: assert property ((state == atd_pkg::atd_next &&
    next_state == atd_pkg::atd_drive) |=>
    (circ - $past(circ)) == 2'h1 && test_signal == (4'h1 << circ))
    else $error("circuits not visited in order");

  // time limits on each circuit
  a_drive_limit: assert property ((state == atd_pkg::atd_drive &&
    timer >= atd_pkg::cnt_w'(alarm_limit - 1) && !circuit_alarm[circ]) |=>
    run_fail[$past(circ)])
    else $error("missing alarm not recorded as failure");
  a_release_limit: assert property ((state == atd_pkg::atd_release &&
    timer >= atd_pkg::cnt_w'(normal_limit - 1) && circuit_alarm[circ]) |=>
    run_fail[$past(circ)])
    else $error("stuck alarm not recorded as failure");
  a_release_drops: assert property ((state == atd_pkg::atd_release) |->
    test_signal == 4'h0)
    else $error("signal held after alarm");

  // defect indicators
  a_fail_defect: assert property ((state == atd_pkg::atd_finish && |run_fail) |=>
    test_defect && (zone_defect & $past(run_fail)) == $past(run_fail))
    else $error("failure not indicated");
  a_pass_clears: assert property ((state == atd_pkg::atd_finish &&
    run_fail == 4'h0) |=> !test_defect)
    else $error("defect kept after passing run");
  a_defect_holds: assert property ((state != atd_pkg::atd_finish) |=>
    $stable(test_defect))
    else $error("defect changed outside a run end");
  a_zone_clear_reset: assert property ($fell(|zone_defect) |-> $past(panel_reset))
    else $error("zone defect cleared without panel reset");

  // alarm forwarding
  a_mask_tested: assert property ((state == atd_pkg::atd_drive) |=>
    !alarm_forward[$past(circ)])
    else $error("test alarm forwarded");
  a_other_forwarded: assert property ((state == atd_pkg::atd_drive) |=>
    ((alarm_forward ^ $past(circuit_alarm)) & ~(4'h1 << $past(circ))) == 4'h0)
    else $error("alarm of an untested circuit not forwarded");

  // main scenarios
  c_run_pass: cover property ((state == atd_pkg::atd_finish) && run_fail == 4'h0);
  c_run_fail: cover property ((state == atd_pkg::atd_finish) && |run_fail);
  c_held_off: cover property (charger_inhibit && hold_off ##1 !hold_off ##1 test_running);
  c_irq: cover property ($rose(irq));
  c_zone_cleared: cover property ($fell(|zone_defect));
endmodule

// ### atd_resp_model.sv
`timescale 1ns/1ps
// ----------------
// responder model
// ----------------
module atd_resp_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] test_signal,
  input wire logic [3:0] dead,
  input wire logic [3:0] fire,
  input wire logic [7:0] dly,
  output logic [3:0] circuit_alarm
);
  logic [3:0] act = 4'h0;
  // live circuit alarms dly cycles after drive, clears dly after release
  for (genvar i = 0; i < 4; i++) begin : g_c
    always begin
      wait (test_signal[i] === 1'b1);
      repeat (dly) @(posedge pclk);
      act[i] <= !dead[i];
      wait (test_signal[i] === 1'b0);
      repeat (dly) @(posedge pclk);
      act[i] <= 1'b0;
    end
  end
  // a real fire shows on top of the test path
  assign circuit_alarm = presetn ? (act | fire) : 4'h0;
endmodule

// ### auto_detector_test_sequencer_bench.sv
`timescale 1ns/1ps
module auto_detector_test_sequencer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic charger_inhibit, panel_reset, test_defect, test_running;
  logic fire_state, self_test_active, self_test_failed, non_latching, zone_alarm_any;
  logic [7:0] paddr, dly;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] circuit_alarm, test_signal, zone_defect, alarm_forward, dead, fire, last, fd;
  logic [4:0] hold;
  logic [3:0] seq[$];
  int failures, checks, cyc;
  assign {zone_alarm_any, non_latching, self_test_failed, self_test_active, fire_state} = hold;
  atd_sequencer #(.alarm_limit(20), .normal_limit(20)) atd_sequencer_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .charger_inhibit,
    .panel_reset, .fire_state, .self_test_active, .self_test_failed, .non_latching,
    .zone_alarm_any, .circuit_alarm, .test_signal, .zone_defect, .alarm_forward,
    .test_defect, .test_running, .irq);
  atd_resp_model atd_resp_model_i (.pclk, .presetn, .test_signal, .dead, .fire, .dly,
    .circuit_alarm);
  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ------------
  // shared tasks
  // ------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk("pready", pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", r, x);
  endtask
  task automatic hour();
    charger_inhibit <= 1'b0;
    @(posedge pclk);
    charger_inhibit <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic wait_run(input logic v, input int lim);
    for (int n = 0; n < lim && test_running !== v; n++) @(posedge pclk);
    chk("test_running", test_running, v);
  endtask
  task automatic run();
    wait_run(1'b1, 4);
    wait_run(1'b0, 600);
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // cycle ceiling, visit log and forwarding watch
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      end_sim();
    end
    if (test_signal != 4'h0 && test_signal != last) seq.push_back(test_signal);
    last <= test_signal;
    fd <= fire;
    if (test_running === 1'b1 && (fire | fd) == 4'h0) chk("fwd", alarm_forward, 4'h0);
  end
  // -----
  // tests
  // -----
  initial begin
    {psel, penable, pwrite, charger_inhibit, panel_reset} = 5'h0;
    {paddr, pwdata, hold, dead, fire, last, fd} = '0;
    presetn = 1'b0;
    dly = 8'h0f;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(atd_pkg::addr_ctrl, atd_pkg::ctrl_reset_val);
    rd(atd_pkg::addr_iclr, 32'h0);
    apb(1'b1, 8'h40, 32'h0);
    chk("pslverr", e, 1'b1);
    apb(1'b1, atd_pkg::addr_ien, 32'h3);
    rd(atd_pkg::addr_ien, 32'h3);
    $display("registers done");
    hour();
    run();
    chk("visits", seq.size(), 4);
    foreach (seq[k]) chk("order", seq[k], 32'h1 << k);
    chk("test_defect", test_defect, 1'b0);
    chk("zone_defect", zone_defect, 4'h0);
    rd(atd_pkg::addr_istat, 32'h1);
    chk("irq", irq, 1'b1);
    apb(1'b1, atd_pkg::addr_iclr, 32'h3);
    @(posedge pclk);
    chk("irq", irq, 1'b0);
    repeat (100) @(posedge pclk);
    chk("visits", seq.size(), 4);
    $display("pass run done");
    dly <= 8'h03;
    dead <= 4'h4;
    hour();
    run();
    chk("zone_defect", zone_defect, 4'h4);
    chk("test_defect", test_defect, 1'b1);
    rd(atd_pkg::addr_istat, 32'h2);
    dead <= 4'h0;
    hour();
    repeat (30) @(posedge pclk);
    chk("test_running", test_running, 1'b0);
    chk("test_defect", test_defect, 1'b1);
    panel_reset <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("zone_defect", zone_defect, 4'h0);
    panel_reset <= 1'b0;
    run();
    chk("test_defect", test_defect, 1'b0);
    $display("fail run done");
    for (int k = 0; k < 5; k++) begin
      hold <= 5'h1 << k;
      hour();
      repeat (20) @(posedge pclk);
      chk("test_running", test_running, 1'b0);
      hold <= 5'h0;
      wait_run(1'b1, 4);
      fire <= 4'h8;
      repeat (2) @(posedge pclk);
      chk("fwd", alarm_forward, 4'h8);
      fire <= 4'h0;
      wait_run(1'b0, 600);
    end
    $display("hold-off runs done");
    apb(1'b1, atd_pkg::addr_ctrl, 32'h0);
    hour();
    repeat (20) @(posedge pclk);
    chk("test_running", test_running, 1'b0);
    apb(1'b1, atd_pkg::addr_ctrl, atd_pkg::ctrl_reset_val);
    run();
    $display("enable run done");
    fire <= 4'h1;
    hour();
    wait_run(1'b1, 4);
    for (int n = 0; n < 60 && alarm_forward[0] !== 1'b1; n++) @(posedge pclk);
    chk("fwd", alarm_forward, 4'h1);
    wait_run(1'b0, 600);
    chk("zone_defect", zone_defect, 4'h1);
    chk("test_defect", test_defect, 1'b1);
    $display("fire run done");
    end_sim();
  end
endmodule
